// ===== rtl/dls_link_status.sv
// Link status, fault reporting, reset and transceiver control block
`timescale 1ns/1ps
`default_nettype none
`include "dls_params.svh"

module dls_link_status (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic slow_board_clock,
  input wire logic core_reset,
  input wire logic transceiver_reset_in,
  input wire logic [2:0] loop_select,
  input wire logic transceiver_sleep,
  input wire logic [`DLS_NUM_LANES-1:0] pcs_lane_aligned,
  input wire logic [`DLS_NUM_LANES-1:0] pcs_code_err,
  input wire logic [`DLS_NUM_LANES-1:0] pcs_lane_fail,
  input wire logic pcs_bond_done,
  input wire logic rx_proto_err,
  input wire logic rx_in_valid,
  input wire dls_pkg::dls_rx_beat_t rx_in,
  output logic rx_out_valid,
  output dls_pkg::dls_rx_beat_t rx_out,
  output logic channel_ready,
  output logic [`DLS_NUM_LANES-1:0] lane_ready,
  output logic framing_fault,
  output logic transient_fault,
  output logic fatal_fault,
  output dls_pkg::dls_xcvr_ctrl_t xcvr_ctrl,
  output logic xcvr_reset,
  output logic irq,
  input wire logic [`DLS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DLS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NL = `DLS_NUM_LANES;

  dls_pkg::dls_ch_state_t ch_state_r;
  logic [7:0] ver_cnt_r;
  logic xr_s1_r;
  logic xr_s2_r;
  logic xr_s3_r;
  logic xrst_lvl_r;
  logic rst_any;
  logic all_lanes;
  logic lane_drop;
  logic hard_ev;
  logic proto_d_r;
  logic soft_d_r;
  logic soft_any;
  logic ch_rdy_d_r;
  logic fatal_d_r;
  logic sw_rst_r;
  logic rxen_r;
  logic [`DLS_INT_W-1:0] int_r;
  logic [`DLS_INT_W-1:0] mask_r;
  logic [`DLS_INT_W-1:0] int_ev;
  logic [`DLS_INT_W-1:0] int_nxt;
  logic [15:0] soft_cnt_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [`DLS_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_aw;
  logic do_w;
  logic do_ar;
  logic wr_fire;
  logic [`DLS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_hold_nxt;
  logic w_hold_nxt;
  logic bvalid_nxt;
  logic rd_clr;
  logic [31:0] rd_val;
  logic rd_ok;

  dls_reset_debounce u_deb (
    .slow_board_clock(slow_board_clock),
    .arst_n(arst_n),
    .transceiver_reset_in(transceiver_reset_in),
    .xcvr_reset(xcvr_reset)
  );

  // Debounced transceiver reset into the core domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xr_s1_r <= 1'b1;
      xr_s2_r <= 1'b1;
      xr_s3_r <= 1'b1;
      xrst_lvl_r <= 1'b1;
    end else begin
      xr_s1_r <= xcvr_reset;
      xr_s2_r <= xr_s1_r;
      xr_s3_r <= xr_s2_r;
      if (xr_s2_r == xr_s3_r) begin
        xrst_lvl_r <= xr_s3_r;
      end
    end
  end

  // Caller keeps core_reset synchronous and at least one cycle wide
  assign rst_any = core_reset | sw_rst_r | xrst_lvl_r;

  // Per-lane bring-up: aligned must hold for the full init time
  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_lane
      logic [7:0] cnt_r;
      logic rdy_r;
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_r <= 8'h00;
          rdy_r <= 1'b0;
        end else if (rst_any) begin
          cnt_r <= 8'h00;
          rdy_r <= 1'b0;
        end else if (!pcs_lane_aligned[gi] || pcs_lane_fail[gi]) begin
          cnt_r <= 8'h00;
          rdy_r <= 1'b0;
        end else if (!rdy_r) begin
          if (cnt_r == 8'(`DLS_LANE_INIT_CYC - 1)) begin
            rdy_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      end
      assign lane_ready[gi] = rdy_r;
    end
  endgenerate

  assign all_lanes = &lane_ready;
  assign lane_drop = (ch_state_r == dls_pkg::CH_UP) && !all_lanes;
  assign hard_ev = (|(pcs_lane_fail & lane_ready)) | lane_drop;

  // Channel bring-up: lanes, bonding, then a verify period
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_state_r <= dls_pkg::CH_DOWN;
      ver_cnt_r <= 8'h00;
      channel_ready <= 1'b0;
    end else if (rst_any) begin
      ch_state_r <= dls_pkg::CH_DOWN;
      ver_cnt_r <= 8'h00;
      channel_ready <= 1'b0;
    end else begin
      case (ch_state_r)
        dls_pkg::CH_DOWN: begin
          ver_cnt_r <= 8'h00;
          if (all_lanes && !fatal_fault) begin
            ch_state_r <= dls_pkg::CH_BOND;
          end
        end
        dls_pkg::CH_BOND: begin
          if (!all_lanes) begin
            ch_state_r <= dls_pkg::CH_DOWN;
          end else if (pcs_bond_done) begin
            ch_state_r <= dls_pkg::CH_VERIFY;
          end
        end
        dls_pkg::CH_VERIFY: begin
          if (!all_lanes) begin
            ch_state_r <= dls_pkg::CH_DOWN;
          end else if (ver_cnt_r == 8'(`DLS_VERIFY_CYC - 1)) begin
            ch_state_r <= dls_pkg::CH_UP;
            channel_ready <= 1'b1;
          end else begin
            ver_cnt_r <= ver_cnt_r + 8'h01;
          end
        end
        dls_pkg::CH_UP: begin
          if (!all_lanes || hard_ev) begin
            ch_state_r <= dls_pkg::CH_DOWN;
            channel_ready <= 1'b0;
          end
        end
        default: begin
          ch_state_r <= dls_pkg::CH_DOWN;
          channel_ready <= 1'b0;
        end
      endcase
    end
  end

  // Fault outputs; a held input gives framing/transient a single pulse, fatal_fault stays set until reset
  assign soft_any = |(pcs_code_err & lane_ready);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      proto_d_r <= 1'b0;
      soft_d_r <= 1'b0;
      framing_fault <= 1'b0;
      transient_fault <= 1'b0;
    end else begin
      proto_d_r <= rx_proto_err;
      soft_d_r <= soft_any;
      framing_fault <= rx_proto_err && !proto_d_r && !rst_any;
      transient_fault <= soft_any && !soft_d_r && !rst_any;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fatal_fault <= 1'b0;
    end else if (rst_any) begin
      fatal_fault <= 1'b0;
    end else if (hard_ev) begin
      fatal_fault <= 1'b1;
    end
  end

  // Received data only with the channel and every lane up
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_out_valid <= 1'b0;
      rx_out <= '0;
    end else begin
      rx_out_valid <= rx_in_valid && channel_ready && all_lanes && rxen_r
        && !rst_any;
      if (rx_in_valid) begin
        rx_out <= rx_in;
      end
    end
  end

  // Transceiver control, registered once so it comes from a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xcvr_ctrl <= '0;
    end else begin
      xcvr_ctrl.loop_mode <= loop_select;
      xcvr_ctrl.sleep <= transceiver_sleep;
    end
  end

  // Event edges for interrupt status
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_rdy_d_r <= 1'b0;
      fatal_d_r <= 1'b0;
    end else begin
      ch_rdy_d_r <= channel_ready;
      fatal_d_r <= fatal_fault;
    end
  end

  always_comb begin
    int_ev = '0;
    int_ev[`DLS_INT_FRAME] = framing_fault;
    int_ev[`DLS_INT_SOFT] = transient_fault;
    int_ev[`DLS_INT_HARD] = fatal_fault && !fatal_d_r;
    int_ev[`DLS_INT_UP] = channel_ready && !ch_rdy_d_r;
    int_ev[`DLS_INT_DOWN] = !channel_ready && ch_rdy_d_r;
  end

  // Read clears; an event in the same cycle still lands
  assign int_nxt = (rd_clr ? '0 : int_r) | int_ev;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_r <= '0;
      irq <= 1'b0;
    end else begin
      int_r <= int_nxt;
      irq <= |(int_nxt & mask_r);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_cnt_r <= 16'h0000;
    end else if (rst_any) begin
      soft_cnt_r <= 16'h0000;
    end else if (transient_fault && soft_cnt_r != 16'hFFFF) begin
      soft_cnt_r <= soft_cnt_r + 16'h0001;
    end
  end

  // Write path: address and data taken in either order
  assign do_aw = s_axi_awvalid && s_axi_awready;
  assign do_w = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_hold_r || do_aw) && (w_hold_r || do_w)
    && !s_axi_bvalid;
  assign wr_addr = do_aw ? s_axi_awaddr : aw_addr_r;
  assign wr_data = do_w ? s_axi_wdata : w_data_r;
  assign wr_strb = do_w ? s_axi_wstrb : w_strb_r;
  assign aw_hold_nxt = !wr_fire && (aw_hold_r || do_aw);
  assign w_hold_nxt = !wr_fire && (w_hold_r || do_w);
  assign bvalid_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DLS_RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      if (do_aw) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (do_w) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
      s_axi_wready <= !w_hold_nxt && !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_fire) begin
        s_axi_bresp <= (wr_addr == `DLS_OFF_CTRL ||
          wr_addr == `DLS_OFF_INT_MASK) ? `DLS_RESP_OKAY : `DLS_RESP_SLVERR;
      end
    end
  end

  // Control and mask; all fields sit in byte lane 0
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_rst_r <= 1'b0;
      rxen_r <= `DLS_CTRL_RXEN_RST;
      mask_r <= `DLS_INT_MASK_RST;
    end else begin
      sw_rst_r <= 1'b0;
      if (wr_fire && wr_strb[0]) begin
        if (wr_addr == `DLS_OFF_CTRL) begin
          sw_rst_r <= wr_data[`DLS_CTRL_SWRST];
          rxen_r <= wr_data[`DLS_CTRL_RXEN];
        end else if (wr_addr == `DLS_OFF_INT_MASK) begin
          mask_r <= wr_data[`DLS_INT_W-1:0];
        end
      end
    end
  end

  // Read path: one read in flight; unmapped reads give zero, SLVERR
  assign do_ar = s_axi_arvalid && s_axi_arready;
  assign rd_clr = do_ar && (s_axi_araddr == `DLS_OFF_INT_STATUS);

  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `DLS_OFF_CTRL: rd_val[`DLS_CTRL_RXEN] = rxen_r;
      `DLS_OFF_STATUS: begin
        rd_val[`DLS_ST_CHAN] = channel_ready;
        rd_val[`DLS_ST_FATAL] = fatal_fault;
        rd_val[`DLS_ST_XRST] = xrst_lvl_r;
        rd_val[`DLS_ST_LANE_LSB +: `DLS_NUM_LANES] = lane_ready;
      end
      `DLS_OFF_INT_STATUS: rd_val[`DLS_INT_W-1:0] = int_r;
      `DLS_OFF_INT_MASK: rd_val[`DLS_INT_W-1:0] = mask_r;
      `DLS_OFF_SOFT_CNT: rd_val[15:0] = soft_cnt_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DLS_RESP_OKAY;
    end else if (do_ar) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `DLS_RESP_OKAY : `DLS_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/dls_params.svh
// Constants of the link status and reset block: offsets, fields, timing
`ifndef DLS_PARAMS_SVH
`define DLS_PARAMS_SVH

`define DLS_NUM_LANES 4
`define DLS_DATA_W 32
`define DLS_ADDR_W 8

// Core clock period and lane/channel bring-up times
`define DLS_CLK_PERIOD_PS 5000
`define DLS_LANE_INIT_NS 100
`define DLS_VERIFY_NS 200
`define DLS_LANE_INIT_CYC \
  ((`DLS_LANE_INIT_NS * 1000 + `DLS_CLK_PERIOD_PS - 1) / `DLS_CLK_PERIOD_PS)
`define DLS_VERIFY_CYC \
  ((`DLS_VERIFY_NS * 1000 + `DLS_CLK_PERIOD_PS - 1) / `DLS_CLK_PERIOD_PS)

// Debounce length, in slow board clock cycles
`define DLS_DEB_CYC 4

// Register byte offsets
`define DLS_OFF_CTRL 8'h00
`define DLS_OFF_STATUS 8'h04
`define DLS_OFF_INT_STATUS 8'h08
`define DLS_OFF_INT_MASK 8'h0C
`define DLS_OFF_SOFT_CNT 8'h10

// Control fields and reset value
`define DLS_CTRL_SWRST 0
`define DLS_CTRL_RXEN 1
`define DLS_CTRL_RXEN_RST 1'b1

// Status fields
`define DLS_ST_CHAN 0
`define DLS_ST_FATAL 1
`define DLS_ST_XRST 2
`define DLS_ST_LANE_LSB 4

// Interrupt status / mask fields
`define DLS_INT_W 5
`define DLS_INT_FRAME 0
`define DLS_INT_SOFT 1
`define DLS_INT_HARD 2
`define DLS_INT_UP 3
`define DLS_INT_DOWN 4
`define DLS_INT_MASK_RST 5'h00

// Bus responses
`define DLS_RESP_OKAY 2'h0
`define DLS_RESP_SLVERR 2'h2

`endif

// ===== rtl/dls_pkg.sv
// Types shared by the link status and reset block
`default_nettype none
package dls_pkg;

  typedef enum logic [1:0] {
    CH_DOWN,
    CH_BOND,
    CH_VERIFY,
    CH_UP
  } dls_ch_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
  } dls_rx_beat_t;

  typedef struct packed {
    logic [2:0] loop_mode;
    logic sleep;
  } dls_xcvr_ctrl_t;

endpackage
`default_nettype wire

// ===== rtl/dls_reset_debounce.sv
// Transceiver reset debouncer on the slow board clock
`timescale 1ns/1ps
`default_nettype none
`include "dls_params.svh"

module dls_reset_debounce (
  input wire logic slow_board_clock,
  input wire logic arst_n,
  input wire logic transceiver_reset_in,
  output logic xcvr_reset
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [3:0] cnt_r;

  // Core clock is stopped during this reset, so all of it runs here
  always_ff @(posedge slow_board_clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= transceiver_reset_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Output changes only after the new level held for the full count
  always_ff @(posedge slow_board_clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      xcvr_reset <= 1'b1;
    end else if (s2_r != s3_r || s3_r == xcvr_reset) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == 4'(`DLS_DEB_CYC - 1)) begin
      cnt_r <= 4'h0;
      xcvr_reset <= s3_r;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/dls_link_status_asserts.sv
// Assertion checker for the link status block
`timescale 1ns/1ps
`default_nettype none
`include "dls_params.svh"
module dls_link_status_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic core_reset,
  input wire logic rx_proto_err,
  input wire logic rx_in_valid,
  input wire dls_pkg::dls_rx_beat_t rx_in,
  input wire logic [2:0] loop_select,
  input wire logic transceiver_sleep,
  input wire logic [`DLS_NUM_LANES-1:0] pcs_lane_aligned,
  input wire logic rx_out_valid,
  input wire dls_pkg::dls_rx_beat_t rx_out,
  input wire logic channel_ready,
  input wire logic [`DLS_NUM_LANES-1:0] lane_ready,
  input wire logic framing_fault,
  input wire logic transient_fault,
  input wire logic fatal_fault,
  input wire dls_pkg::dls_xcvr_ctrl_t xcvr_ctrl,
  input wire logic xcvr_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_frame_pulse: assert property (framing_fault |-> $past(rx_proto_err)
    ##1 !framing_fault) else $error("framing_fault pulse wrong");
  a_soft_pulse: assert property (transient_fault |=> !transient_fault)
    else $error("transient_fault longer than one cycle");
  // Write traffic excluded: a control write may reset the core
  a_fatal_hold: assert property (fatal_fault && !core_reset
    && !xcvr_reset && !s_axi_awvalid && !s_axi_bvalid |=> fatal_fault)
    else $error("fatal_fault dropped without reset");
  a_fatal_down: assert property (fatal_fault |=> !channel_ready)
    else $error("channel up with fatal_fault");
  a_reset_clear: assert property (core_reset |=> !channel_ready
    && !(|lane_ready) && !fatal_fault) else $error("core reset not clearing");
  a_xrst_hold: assert property (xcvr_reset [*6] |-> !channel_ready
    && !(|lane_ready)) else $error("ready during transceiver reset");
  a_rx_gate: assert property (rx_out_valid |-> $past(rx_in_valid)
    && $past(channel_ready) && $past(&lane_ready) && rx_out == $past(rx_in))
    else $error("beat delivered wrongly");
  a_ctrl_route: assert property ($past(arst_n) |->
    xcvr_ctrl.loop_mode == $past(loop_select)
    && xcvr_ctrl.sleep == $past(transceiver_sleep))
    else $error("transceiver control not routed");
  a_lane_up: assert property ($rose(lane_ready[0])
    |-> $past(pcs_lane_aligned[0])) else $error("lane ready unaligned");
  a_chan_up: assert property ($rose(channel_ready) |-> &lane_ready)
    else $error("channel up without all lanes");
  a_wr_resp: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_b_hold: assert property (s_b_wait |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind dls_link_status dls_link_status_asserts u_chk (.core_clk, .arst_n,
  .core_reset, .rx_proto_err, .rx_in_valid, .rx_in, .loop_select,
  .transceiver_sleep, .pcs_lane_aligned, .rx_out_valid, .rx_out,
  .channel_ready, .lane_ready, .framing_fault, .transient_fault,
  .fatal_fault, .xcvr_ctrl, .xcvr_reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ===== testbench/dls_pcs_model.sv
// Behavioural lane and bonding side facing the status block
`timescale 1ns/1ps
`default_nettype none
module dls_pcs_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic inj_code,
  input wire logic inj_fail,
  output logic [3:0] pcs_lane_aligned,
  output logic [3:0] pcs_code_err,
  output logic [3:0] pcs_lane_fail,
  output logic pcs_bond_done
);
  logic [5:0] bond_cnt_r;
  // Bonding finishes late, so the block must wait for it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bond_cnt_r <= 6'h00;
    end else if (!go) begin
      bond_cnt_r <= 6'h00;
    end else if (bond_cnt_r != 6'h1E) begin
      bond_cnt_r <= bond_cnt_r + 6'h01;
    end
  end
  assign pcs_lane_aligned = {4{go}};
  assign pcs_bond_done = (bond_cnt_r == 6'h1E);
  assign pcs_code_err = {3'h0, inj_code};
  assign pcs_lane_fail = {2'h0, inj_fail, 1'b0};
endmodule
`default_nettype wire

// ===== testbench/tb_dls_link_status.sv
// Self-checking bench for the link status block
`timescale 1ns/1ps
`default_nettype none
`include "dls_params.svh"
module tb_dls_link_status;
  logic core_clk = 1'b0, slow_clk = 1'b1, arst_n = 1'b0, core_reset = 1'b0;
  logic xrst_in = 1'b1, sleep = 1'b0, rx_in_valid = 1'b0, proto_err = 1'b0;
  logic go = 1'b0, inj_code = 1'b0, inj_fail = 1'b0;
  logic [2:0] loop_sel = 3'h0;
  dls_pkg::dls_rx_beat_t rx_in = 33'h0, rx_out;
  dls_pkg::dls_xcvr_ctrl_t xcvr_ctrl;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, bond_done;
  logic rx_out_valid, channel_ready, framing_fault, transient_fault;
  logic fatal_fault, xcvr_reset;
  logic [3:0] lane_ready, aligned, code_err, lane_fail;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0, checks = 0, i, nf, ns;
  always #2.5 core_clk = ~core_clk;
  // Unrelated phase to the core clock
  always #3.7 slow_clk = ~slow_clk;
  dls_pcs_model u_pcs (.core_clk(core_clk), .arst_n(arst_n), .go(go),
    .inj_code(inj_code), .inj_fail(inj_fail), .pcs_lane_aligned(aligned),
    .pcs_code_err(code_err), .pcs_lane_fail(lane_fail),
    .pcs_bond_done(bond_done));
  dls_link_status u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .slow_board_clock(slow_clk), .core_reset(core_reset),
    .transceiver_reset_in(xrst_in), .loop_select(loop_sel),
    .transceiver_sleep(sleep), .pcs_lane_aligned(aligned),
    .pcs_code_err(code_err), .pcs_lane_fail(lane_fail),
    .pcs_bond_done(bond_done), .rx_proto_err(proto_err),
    .rx_in_valid(rx_in_valid), .rx_in(rx_in), .rx_out_valid(rx_out_valid),
    .rx_out(rx_out), .channel_ready(channel_ready), .lane_ready(lane_ready),
    .framing_fault(framing_fault), .transient_fault(transient_fault),
    .fatal_fault(fatal_fault), .xcvr_ctrl(xcvr_ctrl),
    .xcvr_reset(xcvr_reset), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task stop_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [33:0] seen, input logic [33:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ak, wk;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ak = 1'b0;
    wk = 1'b0;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) ak = 1'b1;
      if (ak) awvalid <= 1'b0;
      if (wready === 1'b1) wk = 1'b1;
      if (wk) wvalid <= 1'b0;
    end while (!(ak && wk));
    // Late bready makes the response wait one cycle
    @(posedge core_clk);
    bready <= 1'b1;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task beat(input dls_pkg::dls_rx_beat_t b);
    rx_in <= b;
    rx_in_valid <= 1'b1;
    @(posedge core_clk);
    rx_in_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_up(int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    wait_up(2);
    arst_n <= 1'b1;
    chk(xcvr_reset, 1'b1, "no transceiver reset at power-up");
    wait_up(8);
    xrst_in <= 1'b0;
    for (i = 0; i < 200 && xcvr_reset !== 1'b0; i++) @(posedge core_clk);
    chk(xcvr_reset, 1'b0, "transceiver reset stuck");
    wait_up(6);
    beat({32'h1234_5678, 1'b0});
    chk(rx_out_valid, 1'b0, "beat passed while down");
    wr(`DLS_OFF_INT_MASK, 32'h0000_001F, r);
    chk(r, `DLS_RESP_OKAY, "mask write refused");
    wr(`DLS_OFF_STATUS, 32'h0000_0001, r);
    chk(r, `DLS_RESP_SLVERR, "read-only write taken");
    rd(8'h40, d, r);
    chk({r, d}, {`DLS_RESP_SLVERR, 32'h0}, "unmapped read");
    go <= 1'b1;
    wait_up(15);
    chk(lane_ready, 4'h0, "lanes ready too early");
    wait_up(10);
    chk(lane_ready, 4'hF, "lanes not ready");
    while (bond_done !== 1'b1) @(posedge core_clk);
    wait_up(35);
    chk(channel_ready, 1'b0, "channel up before verify");
    wait_up(15);
    chk(channel_ready, 1'b1, "channel not up");
    chk(irq, 1'b1, "no channel up interrupt");
    rd(`DLS_OFF_STATUS, d, r);
    chk(d, 32'hF << `DLS_ST_LANE_LSB | 32'h1 << `DLS_ST_CHAN, "st");
    rd(`DLS_OFF_INT_STATUS, d, r);
    chk(d, 32'h1 << `DLS_INT_UP, "int status up");
    wait_up(2);
    chk(irq, 1'b0, "irq not cleared by read");
    beat({32'hA5C3_0F96, 1'b1});
    chk(rx_out_valid, 1'b1, "beat lost while up");
    chk(rx_out, {32'hA5C3_0F96, 1'b1}, "beat corrupted");
    proto_err <= 1'b1;
    inj_code <= 1'b1;
    nf = 0;
    ns = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk);
      nf += framing_fault;
      ns += transient_fault;
      if (i == 2) begin
        proto_err <= 1'b0;
        inj_code <= 1'b0;
      end
    end
    chk(nf, 1, "framing pulse count");
    chk(ns, 1, "soft pulse count");
    rd(`DLS_OFF_INT_STATUS, d, r);
    chk(d, 32'h1 << `DLS_INT_FRAME | 32'h1 << `DLS_INT_SOFT, "int faults");
    rd(`DLS_OFF_SOFT_CNT, d, r);
    chk(d, 32'h0000_0001, "soft error count");
    wr(`DLS_OFF_INT_MASK, 32'h0, r);
    proto_err <= 1'b1;
    wait_up(4);
    proto_err <= 1'b0;
    chk(irq, 1'b0, "masked interrupt raised");
    rd(`DLS_OFF_INT_STATUS, d, r);
    chk(d, 32'h1 << `DLS_INT_FRAME, "masked event not recorded");
    for (i = 0; i < 16; i++) begin
      {loop_sel, sleep} <= i[3:0];
      wait_up(2);
      chk(xcvr_ctrl, i[3:0], "transceiver control");
    end
    inj_fail <= 1'b1;
    wait_up(2);
    inj_fail <= 1'b0;
    wait_up(6);
    chk({fatal_fault, channel_ready}, 2'h2, "hard error not sticky");
    rd(`DLS_OFF_INT_STATUS, d, r);
    chk(d, 32'h1 << `DLS_INT_HARD | 32'h1 << `DLS_INT_DOWN, "hard");
    core_reset <= 1'b1;
    wait_up(1);
    core_reset <= 1'b0;
    wait_up(2);
    chk({fatal_fault, lane_ready}, 5'h00, "core reset ignored");
    wait_up(30);
    inj_fail <= 1'b1;
    wait_up(2);
    inj_fail <= 1'b0;
    chk(fatal_fault, 1'b1, "second hard error missed");
    wr(`DLS_OFF_CTRL, 32'h0000_0003, r);
    chk(fatal_fault, 1'b0, "software reset kept fatal");
    rd(`DLS_OFF_CTRL, d, r);
    chk(d, 32'h1 << `DLS_CTRL_RXEN, "control readback");
    xrst_in <= 1'b1;
    for (i = 0; i < 200 && xcvr_reset !== 1'b1; i++) @(posedge core_clk);
    wait_up(8);
    chk({xcvr_reset, channel_ready, lane_ready}, 6'h20, "xrst");
    xrst_in <= 1'b0;
    stop_test;
  end
endmodule
`default_nettype wire
